// ---- hw/bst_pkg.sv ----
package bst_pkg;

  // ---------------------------------------------------------------------------
  // Register sizes and special cells
  // ---------------------------------------------------------------------------
  localparam int BST_IR_W = 3;
  localparam int BST_ID_W = 32;
  localparam int BST_BSR_W = 64;
  localparam int BST_OE_CELL = 47;
  localparam int BST_TLR_TMS_COUNT = 5;

  // ---------------------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BST_IR_EXTEST = 3'h0;
  localparam logic [2:0] BST_IR_IDCODE = 3'h1;
  localparam logic [2:0] BST_IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] BST_IR_SAMPLE = 3'h4;
  localparam logic [2:0] BST_IR_BYPASS = 3'h7;
  localparam logic [1:0] BST_IR_CAPTURE = 2'h1;

  // The identification value is arbitrary; bit 0 is kept at one.
  localparam logic [31:0] BST_IDCODE_DEFAULT = 32'h0A5C_0001;

  // Only the output enable cell is preset high.
  localparam logic [63:0] BST_BSR_RESET = 64'h0000_8000_0000_0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    BST_TLR = 4'h0, BST_RTI = 4'h1, BST_SEL_DR = 4'h3, BST_CAP_DR = 4'h2,
    BST_SHIFT_DR = 4'h6, BST_EX1_DR = 4'h7, BST_PAUSE_DR = 4'h5, BST_EX2_DR = 4'h4,
    BST_UPD_DR = 4'hC, BST_SEL_IR = 4'hD, BST_CAP_IR = 4'hF, BST_SHIFT_IR = 4'hE,
    BST_EX1_IR = 4'hA, BST_PAUSE_IR = 4'hB, BST_EX2_IR = 4'h9, BST_UPD_IR = 4'h8
  } bst_state_type;

  typedef enum logic [1:0] {
    BST_PATH_BYP = 2'h0, BST_PATH_ID = 2'h1, BST_PATH_BSR = 2'h3
  } bst_path_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_jtag_in_type;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_jtag_out_type;

  typedef struct packed {
    logic drive_en;
    logic q_oe;
    logic [BST_BSR_W-1:0] value;
  } bst_mem_out_type;

  typedef struct packed {
    logic tck_s1;
    logic tck_s2;
    logic tck_d;
    logic tms_s1;
    logic tms_s2;
    logic tdi_s1;
    logic tdi_s2;
    logic [BST_BSR_W-1:0] cap_s1;
    logic [BST_BSR_W-1:0] cap_s2;
    bst_state_type st;
    logic [BST_IR_W-1:0] ir;
    logic [BST_IR_W-1:0] ir_sh;
    logic byp;
    logic [BST_ID_W-1:0] id_sh;
    logic [BST_BSR_W-1:0] bsr_sh;
    logic [BST_BSR_W-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
    logic q_oe;
    logic drive;
    logic [2:0] ones;
  } bst_tap_state_type;

  localparam bst_tap_state_type BST_TAP_RESET = '{
    tms_s1: 1'b1, tms_s2: 1'b1, tdi_s1: 1'b1, tdi_s2: 1'b1, st: BST_TLR,
    ir: BST_IR_IDCODE, bsr_upd: BST_BSR_RESET, q_oe: 1'b1, default: '0};

endpackage : bst_pkg

// ---- hw/bst_tap.sv ----
`timescale 1ns/1ns
// Function
// - Sample on test clock rise, drive on fall
// - Mode select steers controller; idle reads high
// - Data in enters selected register MSB
// - Data out is LSB, falls, shift-only
// - Five high mode selects force reset state
// - Power-up reset floats data out
// - Exactly one register chosen by instruction
// - Three-bit instruction, identify at reset
// - Capture-IR loads low bits with 01
// - One-bit bypass cleared at capture
// - Boundary chain captures pins, shifts them
// - Identify loads fixed 32-bit code
// - New instruction acts after Update-IR
// - Identify selects identification register path
// - Float instruction selects chain, floats outputs
// - Cell 47 gates outputs under external test
// - External test drives preloaded values out
module bst_tap
  import bst_pkg::*;
#(
  parameter logic [31:0] IDCODE_VALUE = BST_IDCODE_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Scan pins
  input bst_jtag_in_type jtag_in,
  output bst_jtag_out_type jtag_out,
  // Memory pin ring
  input wire logic [BST_BSR_W-1:0] pins_in,
  output bst_mem_out_type mem_out
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic bst_path_type bst_path(input logic [BST_IR_W-1:0] code);
    bst_path_type p;
    p = BST_PATH_BYP;
    if (code == BST_IR_EXTEST || code == BST_IR_SAMPLE || code == BST_IR_SAMPLE_Z) begin
      p = BST_PATH_BSR;
    end else if (code == BST_IR_IDCODE) begin
      p = BST_PATH_ID;
    end
    return p;
  endfunction : bst_path

  function automatic bst_state_type bst_next(input bst_state_type st, input logic tms);
    bst_state_type n;
    n = st;
    unique case (st)
      BST_TLR: n = tms ? BST_TLR : BST_RTI;
      BST_RTI: n = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: n = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: n = tms ? BST_EX1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: n = tms ? BST_EX1_DR : BST_SHIFT_DR;
      BST_EX1_DR: n = tms ? BST_UPD_DR : BST_PAUSE_DR;
      BST_PAUSE_DR: n = tms ? BST_EX2_DR : BST_PAUSE_DR;
      BST_EX2_DR: n = tms ? BST_UPD_DR : BST_SHIFT_DR;
      BST_UPD_DR: n = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: n = tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: n = tms ? BST_EX1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: n = tms ? BST_EX1_IR : BST_SHIFT_IR;
      BST_EX1_IR: n = tms ? BST_UPD_IR : BST_PAUSE_IR;
      BST_PAUSE_IR: n = tms ? BST_EX2_IR : BST_PAUSE_IR;
      BST_EX2_IR: n = tms ? BST_UPD_IR : BST_SHIFT_IR;
      BST_UPD_IR: n = tms ? BST_SEL_DR : BST_RTI;
    endcase
    return n;
  endfunction : bst_next

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  bst_tap_state_type s_r;
  bst_tap_state_type s_nxt;
  logic rise;
  logic fall;
  bst_path_type path;
  bst_state_type st_nxt;

  assign rise = s_r.tck_s2 & ~s_r.tck_d;
  assign fall = ~s_r.tck_s2 & s_r.tck_d;
  assign path = bst_path(s_r.ir);
  assign st_nxt = bst_next(s_r.st, s_r.tms_s2);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // The pull-up on the mode select pin is modelled by the high reset value.
    s_nxt.tck_s1 = jtag_in.tck;
    s_nxt.tck_s2 = s_r.tck_s1;
    s_nxt.tck_d = s_r.tck_s2;
    s_nxt.tms_s1 = jtag_in.tms;
    s_nxt.tms_s2 = s_r.tms_s1;
    s_nxt.tdi_s1 = jtag_in.tdi;
    s_nxt.tdi_s2 = s_r.tdi_s1;
    s_nxt.cap_s1 = pins_in;
    s_nxt.cap_s2 = s_r.cap_s1;

    if (rise) begin
      s_nxt.st = st_nxt;
      if (s_r.tms_s2) begin
        s_nxt.ones = (s_r.ones == 3'h7) ? 3'h7 : 3'(s_r.ones + 3'h1);
      end else begin
        s_nxt.ones = 3'h0;
      end

      if (s_r.st == BST_CAP_IR) begin
        s_nxt.ir_sh = {1'b0, BST_IR_CAPTURE};
      end
      if (s_r.st == BST_SHIFT_IR) begin
        s_nxt.ir_sh = {s_r.tdi_s2, s_r.ir_sh[BST_IR_W-1:1]};
      end
      if (s_r.st == BST_UPD_IR) begin
        s_nxt.ir = s_r.ir_sh;
      end

      if (s_r.st == BST_CAP_DR) begin
        unique case (path)
          BST_PATH_BYP: s_nxt.byp = 1'b0;
          BST_PATH_ID: s_nxt.id_sh = IDCODE_VALUE;
          BST_PATH_BSR: s_nxt.bsr_sh = s_r.cap_s2;
        endcase
      end
      if (s_r.st == BST_SHIFT_DR) begin
        unique case (path)
          BST_PATH_BYP: s_nxt.byp = s_r.tdi_s2;
          BST_PATH_ID: s_nxt.id_sh = {s_r.tdi_s2, s_r.id_sh[BST_ID_W-1:1]};
          BST_PATH_BSR: s_nxt.bsr_sh = {s_r.tdi_s2, s_r.bsr_sh[BST_BSR_W-1:1]};
        endcase
      end
      if (s_r.st == BST_UPD_DR && path == BST_PATH_BSR) begin
        s_nxt.bsr_upd = s_r.bsr_sh;
      end

      // Entering the reset state restores the instruction and the output cell.
      if (st_nxt == BST_TLR) begin
        s_nxt.ir = BST_IR_IDCODE;
        s_nxt.bsr_upd[BST_OE_CELL] = 1'b1;
      end
    end

    if (fall) begin
      if (s_r.st == BST_SHIFT_IR) begin
        s_nxt.tdo = s_r.ir_sh[0];
      end else begin
        unique case (path)
          BST_PATH_BYP: s_nxt.tdo = s_r.byp;
          BST_PATH_ID: s_nxt.tdo = s_r.id_sh[0];
          BST_PATH_BSR: s_nxt.tdo = s_r.bsr_sh[0];
        endcase
      end
      s_nxt.tdo_oe = (s_r.st == BST_SHIFT_IR) || (s_r.st == BST_SHIFT_DR);
    end

    // The memory function keeps running; only the output path is steered here.
    s_nxt.drive = (s_r.ir == BST_IR_EXTEST);
    if (s_r.ir == BST_IR_SAMPLE_Z) begin
      s_nxt.q_oe = 1'b0;
    end else if (s_r.ir == BST_IR_EXTEST) begin
      s_nxt.q_oe = s_r.bsr_upd[BST_OE_CELL];
    end else begin
      s_nxt.q_oe = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= BST_TAP_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign jtag_out.tdo = s_r.tdo;
  assign jtag_out.tdo_oe = s_r.tdo_oe;
  assign mem_out.drive_en = s_r.drive;
  assign mem_out.q_oe = s_r.q_oe;
  assign mem_out.value = s_r.bsr_upd;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_rise_in(bst_state_type st_c);
    rise && (s_r.st == st_c);
  endsequence

  sequence seq_fall_in(bst_state_type st_c);
    fall && (s_r.st == st_c);
  endsequence

  AST_TLR_AFTER_FIVE: assert property (
    (s_r.ones >= 3'(BST_TLR_TMS_COUNT)) |-> (s_r.st == BST_TLR))
    else $error("Controller not in reset after five high mode selects.");

  AST_STATE_ON_RISE: assert property (
    (s_r.st != $past(s_r.st)) |-> $past(rise))
    else $error("Controller state moved without a test clock rise.");

  AST_TDO_ON_FALL: assert property (
    $changed(s_r.tdo) || $changed(s_r.tdo_oe) |-> $past(fall))
    else $error("Data out changed without a test clock fall.");

  AST_OE_SHIFT_ONLY: assert property (
    $rose(s_r.tdo_oe) |-> (s_r.st == BST_SHIFT_DR || s_r.st == BST_SHIFT_IR))
    else $error("Data out enabled outside a shift state.");

  AST_IR_RESET: assert property (
    (s_r.st == BST_TLR) |-> (s_r.ir == BST_IR_IDCODE) && s_r.bsr_upd[BST_OE_CELL])
    else $error("Reset state without identify instruction or output cell.");

  AST_CAPIR_01: assert property (
    seq_rise_in(BST_CAP_IR) |=> (s_r.ir_sh[1:0] == BST_IR_CAPTURE))
    else $error("Capture-IR did not load the fixed pattern.");

  AST_IR_UPDATE: assert property (
    $changed(s_r.ir) && (s_r.st != BST_TLR) |-> ($past(s_r.st) == BST_UPD_IR))
    else $error("Instruction changed outside Update-IR.");

  AST_BYP_CLEAR: assert property (
    seq_rise_in(BST_CAP_DR) ##0 (path == BST_PATH_BYP) |=> !s_r.byp)
    else $error("Bypass bit not cleared at capture.");

  AST_ID_CAPTURE: assert property (
    seq_rise_in(BST_CAP_DR) ##0 (s_r.ir == BST_IR_IDCODE) |=> (s_r.id_sh == IDCODE_VALUE))
    else $error("Identification code not captured.");

  AST_BSR_MSB: assert property (
    seq_rise_in(BST_SHIFT_DR) ##0 (path == BST_PATH_BSR)
      |=> (s_r.bsr_sh[BST_BSR_W-1] == $past(s_r.tdi_s2)))
    else $error("Data in did not enter the chain MSB.");

  AST_ID_LSB_OUT: assert property (
    seq_fall_in(BST_SHIFT_DR) ##0 (s_r.ir == BST_IR_IDCODE)
      |=> (s_r.tdo == $past(s_r.id_sh[0])) && s_r.tdo_oe)
    else $error("Identification LSB not presented on data out.");

  AST_FLOAT_Q: assert property (
    (s_r.ir == BST_IR_SAMPLE_Z) ##1 (s_r.ir == BST_IR_SAMPLE_Z) |-> !s_r.q_oe)
    else $error("Outputs not floated under float instruction.");

  AST_EXTEST_CELL: assert property (
    (s_r.ir == BST_IR_EXTEST) |=> (s_r.q_oe == $past(s_r.bsr_upd[BST_OE_CELL])) && s_r.drive)
    else $error("Output enable not taken from cell 47.");

  AST_IR_LSB_OUT: assert property (
    seq_fall_in(BST_SHIFT_IR) |=> (s_r.tdo == $past(s_r.ir_sh[0])) && s_r.tdo_oe)
    else $error("Instruction LSB not presented on data out.");

  AST_OE_OFF_IDLE: assert property (
    fall && (s_r.st != BST_SHIFT_DR) && (s_r.st != BST_SHIFT_IR) |=> !s_r.tdo_oe)
    else $error("Data out still driven outside a shift state.");

  AST_IR_MSB: assert property (
    seq_rise_in(BST_SHIFT_IR) |=> (s_r.ir_sh[BST_IR_W-1] == $past(s_r.tdi_s2)))
    else $error("Data in did not enter the instruction MSB.");

  AST_BYP_SHIFT: assert property (
    seq_rise_in(BST_SHIFT_DR) ##0 (path == BST_PATH_BYP)
      |=> (s_r.byp == $past(s_r.tdi_s2)))
    else $error("Bypass bit did not take data in.");

  AST_BYP_OUT: assert property (
    seq_fall_in(BST_SHIFT_DR) ##0 (s_r.ir == BST_IR_BYPASS)
      |=> (s_r.tdo == $past(s_r.byp)))
    else $error("All-ones instruction did not route the bypass bit.");

  AST_BSR_CAPTURE: assert property (
    seq_rise_in(BST_CAP_DR) ##0 (path == BST_PATH_BSR)
      |=> (s_r.bsr_sh == $past(s_r.cap_s2)))
    else $error("Boundary chain did not capture the pin ring.");

  AST_BSR_UPDATE: assert property (
    seq_rise_in(BST_UPD_DR) ##0 (path == BST_PATH_BSR)
      |=> (s_r.bsr_upd == $past(s_r.bsr_sh)))
    else $error("Preload register not loaded at Update-DR.");

  AST_TLR_ENTRY: assert property (
    seq_rise_in(BST_SEL_IR) ##0 s_r.tms_s2
      |=> (s_r.st == BST_TLR) && (s_r.ir == BST_IR_IDCODE))
    else $error("Reset state not entered with identify instruction.");

  AST_Q_NORMAL: assert property (
    (s_r.ir != BST_IR_SAMPLE_Z) && (s_r.ir != BST_IR_EXTEST) |=> s_r.q_oe && !s_r.drive)
    else $error("Output bus disturbed outside boundary output instructions.");

  AST_IR_NEW_ACTS: assert property (
    seq_rise_in(BST_UPD_IR) |=> (s_r.ir == $past(s_r.ir_sh)))
    else $error("Shifted instruction not applied at Update-IR.");

endmodule : bst_tap

// ---- sim/bst_jtag_model.sv ----
`timescale 1ns/1ns
module bst_jtag_model
  import bst_pkg::*;
(
  // Clock
  input wire logic clk,
  // Scan pins
  input bst_jtag_out_type jtag_out,
  output bst_jtag_in_type jtag_in
);
  // -------------------------------------------------------------------------
  // Test clock bit cell
  // -------------------------------------------------------------------------
  // The released data line rests at its pull-up level.
  initial begin
    jtag_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
  end

  // Inputs change at the test clock fall and are taken at its rise.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk);
    jtag_in.tck <= 1'b0;
    jtag_in.tms <= tms;
    jtag_in.tdi <= tdi;
    repeat (4) @(posedge clk);
    jtag_in.tck <= 1'b1;
    repeat (2) @(posedge clk);
    tdo = jtag_out.tdo_oe ? jtag_out.tdo : ~jtag_out.tdo;
    @(posedge clk);
  endtask : step

  // -------------------------------------------------------------------------
  // Scans
  // -------------------------------------------------------------------------
  // Shifts LSB first, leaves through Update and parks in idle.
  task automatic scan(input logic [63:0] din, input int n, output logic [63:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : scan

  // Only the codes the bench asks for are loaded.
  task automatic ir_scan(input logic [2:0] code, output logic [63:0] dout);
    logic b;
    step(1'b1, 1'b1, b);
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    scan({61'h0, code}, 3, dout);
  endtask : ir_scan

  task automatic dr_scan(input logic [63:0] din, input int n, output logic [63:0] dout);
    logic b;
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    scan(din, n, dout);
  endtask : dr_scan

  // Five rises with mode select high.
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
  endtask : reset_tap
endmodule : bst_jtag_model

// ---- sim/bst_tap_tb.sv ----
`timescale 1ns/1ns
module bst_tap_tb;
  import bst_pkg::*;
  // Arbitrary identification value.
  localparam logic [31:0] ID = 32'h1357_9BDF;
  localparam logic [63:0] PINS = 64'hDEAD_BEEF_0123_4567;
  localparam logic [63:0] D1 = 64'h1234_5678_9ABC_DEF0;
  localparam logic [63:0] D2 = 64'h1234_D678_9ABC_DEF0;
  logic clk;
  logic nrst;
  bst_jtag_in_type jtag_in;
  bst_jtag_out_type jtag_out;
  logic [63:0] pins_in;
  bst_mem_out_type mem_out;
  int n_mismatch;
  int checked;
  int cycles;
  logic [63:0] r;
  logic b;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  bst_tap #(.IDCODE_VALUE(ID)) DUT (.clk(clk), .nrst(nrst), .jtag_in(jtag_in),
    .jtag_out(jtag_out), .pins_in(pins_in), .mem_out(mem_out));
  bst_jtag_model u_ctl (.clk(clk), .jtag_out(jtag_out), .jtag_in(jtag_in));

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Lets the output registers settle before they are looked at.
  task automatic chk_out(input bst_mem_out_type exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(mem_out, exp);
  endtask : chk_out

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic ir(input logic [2:0] code);
    u_ctl.ir_scan(code, r);
    chk(r[1:0], 2'b01);
  endtask : ir

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_power_up();
    chk(jtag_out.tdo_oe, 1'b0);
    chk(mem_out, {2'b01, BST_BSR_RESET});
    u_ctl.step(1'b0, 1'b1, b);
    u_ctl.dr_scan(64'h0, 32, r);
    chk(r, {32'h0, ID});
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_bypass();
    logic [2:0] codes [2] = '{BST_IR_BYPASS, BST_IR_BYPASS};
    foreach (codes[i]) begin
      ir(codes[i]);
      u_ctl.dr_scan(64'hA5, 8, r);
      chk(r, 64'h4A);
    end
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_sample();
    ir(BST_IR_SAMPLE);
    u_ctl.dr_scan(D1, 64, r);
    chk(r, PINS);
    chk_out({2'b01, D1});
    $display("test sample done");
  endtask : t_sample

  task automatic t_extest();
    ir(BST_IR_EXTEST);
    chk_out({2'b10, D1});
    u_ctl.dr_scan(D2, 64, r);
    chk(r, PINS);
    chk_out({2'b11, D2});
    $display("test extest done");
  endtask : t_extest

  task automatic t_float_reset();
    ir(BST_IR_SAMPLE_Z);
    u_ctl.dr_scan(D1, 64, r);
    chk_out({2'b00, D1});
    u_ctl.step(1'b1, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b);
    u_ctl.step(1'b0, 1'b0, b);
    u_ctl.reset_tap();
    chk(jtag_out.tdo_oe, 1'b0);
    // Leaving Shift-DR passes Update-DR, which loads the twice-shifted capture.
    chk_out({2'b01, ({2'b10, PINS[63:2]} | BST_BSR_RESET)});
    u_ctl.step(1'b0, 1'b1, b);
    u_ctl.dr_scan(64'h0, 32, r);
    chk(r, {32'h0, ID});
    $display("test float_reset done");
  endtask : t_float_reset

  initial begin
    nrst = 1'b0;
    pins_in = PINS;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_power_up();
    t_bypass();
    t_sample();
    t_extest();
    t_float_reset();
    finish_test();
  end
endmodule : bst_tap_tb
